// >>> rtl/mtip_core.sv
// Function
// - Decode spans two stages, yet a new group enters every cycle the pipe advances.
// - A context issued in one cycle is never issued the next cycle.
// - Up to two instructions issue per clock, primary plus secondary.
// - Secondary pipe takes a subset of classes, only under pairing checks.
// - Vector instructions go to the primary pipe only.
// - Integer and mask results reach dependents after one clock.
// - Vector results take four clocks, one vector accepted each clock.
// - Load after simple vector store waits four clocks, swizzles longer.
// - Store then load through the data cache costs twelve clocks.
// - A data cache bounce inserts two dead clocks.
// - Fast prefixes add no decode cycles.
// - Size, lock, segment and repeat prefixes add two decode cycles.
// - First decode stage selects thread, rotates, spots early prefixes.
// - Writeback writes integer registers and evaluates the flags.
// - One thread alone gets at most half the issue slots.
// - Four hardware contexts feed the picker.
// - A load miss parks its context until the fill arrives.
`timescale 1ns/100ps
module mtip_core (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [mtip_pkg::NCTX-1:0] ctx_valid,
  input wire mtip_pkg::mtip_byte_t [mtip_pkg::NCTX-1:0] ctx_prefix,
  input wire mtip_pkg::mtip_cls_t [mtip_pkg::NCTX-1:0] ctx_op0,
  input wire mtip_pkg::mtip_cls_t [mtip_pkg::NCTX-1:0] ctx_op1,
  input wire logic [mtip_pkg::NCTX-1:0] ctx_dep,
  input wire logic [mtip_pkg::NCTX-1:0] ctx_swz,
  input wire logic load_miss,
  input wire mtip_pkg::mtip_ctx_t load_miss_ctx,
  input wire logic fill_done,
  input wire mtip_pkg::mtip_ctx_t fill_ctx,
  input wire logic dcache_bounce,
  output logic pick_ack,
  output mtip_pkg::mtip_ctx_t pick_ack_ctx,
  output logic pick_ack_two,
  output logic issue_valid,
  output mtip_pkg::mtip_ctx_t issue_ctx,
  output mtip_pkg::mtip_cls_t issue_u_cls,
  output mtip_pkg::mtip_cls_t issue_v_cls,
  output logic issue_early_pfx,
  output logic wb_rf_we,
  output logic wb_flags_we,
  output mtip_pkg::mtip_ctx_t wb_ctx,
  output logic [mtip_pkg::NCTX-1:0] ctx_suspended
);
  import mtip_pkg::*;

  typedef struct packed {
    mtip_grp_t dec_first;
    mtip_grp_t dec_second;
    logic [NCTX-1:0][LAT_W-1:0] lat;
    logic [NCTX-1:0] susp;
    mtip_cnt_t dead;
    mtip_cnt_t slow;
    logic ack;
    mtip_ctx_t ack_ctx;
    logic ack_two;
    logic iss;
    mtip_ctx_t iss_ctx;
    mtip_cls_t iss_u;
    mtip_cls_t iss_v;
    logic iss_early;
    logic wb_rf;
    logic wb_fl;
    mtip_ctx_t wb_ctx;
  } mtip_core_st_t;

  mtip_core_st_t s;
  mtip_core_st_t next_s;
  mtip_pick_if pk ();

  logic stall;
  logic adv;
  logic paired;
  mtip_grp_t g;
  mtip_lat_t lat0;
  mtip_lat_t lat1;
  mtip_lat_t lat_grp;

  mtip_picker u_picker (
    .ref_clk (ref_clk),
    .reset (reset),
    .pk (pk)
  );

  always_comb begin
    next_s = s;
    // Bounce and slow prefix both freeze the whole pipe in lockstep
    stall = (s.dead != '0) || (s.slow != '0);
    adv = !stall;
    pk.advance = adv;

    // Eligible: fetched, not parked, dependency latency elapsed
    for (int c = 0; c < NCTX; c++) begin
      pk.req[c] = ctx_valid[c] && !s.susp[c] &&
                  (!ctx_dep[c] || s.lat[c] == LAT_ZERO);
    end

    // Rotate the chosen context's group into the decoder
    g.valid = pk.grant_valid;
    g.ctx = pk.grant_ctx;
    g.prefix = ctx_prefix[pk.grant_ctx];
    g.op0 = ctx_op0[pk.grant_ctx];
    g.op1 = ctx_op1[pk.grant_ctx];
    g.early = 1'b0;
    // Second op rides along only if the secondary pipe can take it
    paired = (g.op0 != CLS_NONE) && v_ok(g.op1);
    if (!paired) begin
      g.op1 = CLS_NONE;
    end

    // Latency of the group: slowest of its two results
    lat0 = cls_lat(g.op0, ctx_swz[pk.grant_ctx]);
    lat1 = cls_lat(g.op1, ctx_swz[pk.grant_ctx]);
    lat_grp = (lat0 > lat1) ? lat0 : lat1;

    // Counters run on advances only, so freezes never shorten a wait
    if (adv) begin
      for (int c = 0; c < NCTX; c++) begin
        if (s.lat[c] != LAT_ZERO) begin
          next_s.lat[c] = s.lat[c] - LAT_STEP;
        end
      end
      if (pk.grant_valid) begin
        next_s.lat[pk.grant_ctx] = lat_grp - LAT_STEP;
      end
    end

    // Fetch side drops the group one cycle later; the picker
    // already excludes that context in that cycle
    next_s.ack = adv && pk.grant_valid;
    next_s.ack_ctx = pk.grant_ctx;
    next_s.ack_two = paired;

    // Two-stage decode, a new group each advance
    if (adv) begin
      next_s.dec_first = g;
      next_s.dec_second = s.dec_first;
      next_s.dec_second.early = pfx_early(s.dec_first.prefix);
    end

    // Slow prefix holds the group in second decode two more cycles
    if (adv && s.dec_first.valid && pfx_slow(s.dec_first.prefix)) begin
      next_s.slow = SLOW_CLKS;
    end else if (s.slow != '0) begin
      next_s.slow = s.slow - CNT_ONE;
    end

    // A bounce wins over a running count and restarts it
    if (dcache_bounce) begin
      next_s.dead = DEAD_CLKS;
    end else if (s.dead != '0) begin
      next_s.dead = s.dead - CNT_ONE;
    end

    // Issue: op0 to primary, paired op1 to secondary
    next_s.iss = adv && s.dec_second.valid;
    next_s.iss_ctx = s.dec_second.ctx;
    next_s.iss_u = s.dec_second.op0;
    next_s.iss_v = s.dec_second.op1;
    next_s.iss_early = s.dec_second.early;

    // Writeback: register file and flags for the issued pair
    next_s.wb_rf = s.iss &&
                   (writes_gpr(s.iss_u) || writes_gpr(s.iss_v));
    next_s.wb_fl = s.iss &&
                   (s.iss_u == CLS_INT || s.iss_v == CLS_INT);
    next_s.wb_ctx = s.iss_ctx;

    // Fill clears, a miss in the same cycle still parks
    for (int c = 0; c < NCTX; c++) begin
      if (fill_done && fill_ctx == mtip_ctx_t'(c)) begin
        next_s.susp[c] = 1'b0;
      end
      if (load_miss && load_miss_ctx == mtip_ctx_t'(c)) begin
        next_s.susp[c] = 1'b1;
      end
    end
  end

  // All state in one register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from state
  assign pick_ack = s.ack;
  assign pick_ack_ctx = s.ack_ctx;
  assign pick_ack_two = s.ack_two;
  assign issue_valid = s.iss;
  assign issue_ctx = s.iss_ctx;
  assign issue_u_cls = s.iss_u;
  assign issue_v_cls = s.iss_v;
  assign issue_early_pfx = s.iss_early;
  assign wb_rf_we = s.wb_rf;
  assign wb_flags_we = s.wb_fl;
  assign wb_ctx = s.wb_ctx;
  assign ctx_suspended = s.susp;

  a_issue_alt: assert property (
    @(posedge ref_clk) disable iff (reset)
    (issue_valid && $past(issue_valid)) |->
      issue_ctx != $past(issue_ctx))
    else $error("same context issued in back to back cycles");

  a_decode_depth: assert property (
    @(posedge ref_clk) disable iff (reset)
    (pk.grant_valid && adv ##1 adv ##1 adv) |=>
      (issue_valid && issue_ctx == $past(pk.grant_ctx, 3)))
    else $error("picked group did not issue after two decode stages");

  a_vec_upipe: assert property (
    @(posedge ref_clk) disable iff (reset)
    issue_valid |-> !is_vec(issue_v_cls))
    else $error("vector instruction on the secondary pipe");

  a_vpipe_subset: assert property (
    @(posedge ref_clk) disable iff (reset)
    (issue_valid && issue_v_cls != CLS_NONE) |->
      (v_ok(issue_v_cls) && issue_u_cls != CLS_NONE))
    else $error("secondary pipe issue broke pairing");

  a_bounce_gap: assert property (
    @(posedge ref_clk) disable iff (reset)
    dcache_bounce |=> ##1 !issue_valid [*2])
    else $error("issue inside bounce dead clocks");

  a_slow_gap: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && s.dec_first.valid && pfx_slow(s.dec_first.prefix)) |=>
      ##1 !issue_valid [*2])
    else $error("slow prefix did not add two decode cycles");

  a_fast_free: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && s.dec_first.valid && pfx_fast(s.dec_first.prefix) &&
      !dcache_bounce) |=> adv)
    else $error("fast prefix added decode cycles");

  a_dep_wait: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && pk.grant_valid && ctx_dep[pk.grant_ctx]) |->
      s.lat[pk.grant_ctx] == LAT_ZERO)
    else $error("dependent group picked before result ready");

  a_miss_park: assert property (
    @(posedge ref_clk) disable iff (reset)
    load_miss |=> (ctx_suspended[$past(load_miss_ctx)] &&
      !(pk.grant_valid && pk.grant_ctx == $past(load_miss_ctx))))
    else $error("missing context not parked");

  a_wb_write: assert property (
    @(posedge ref_clk) disable iff (reset)
    (issue_valid && writes_gpr(issue_u_cls)) |=>
      (wb_rf_we && wb_ctx == $past(issue_ctx)))
    else $error("writeback missed a register file write");

  // Frozen cycles must take nothing, or a group would slip past a stall
  a_stall_frozen: assert property (
    @(posedge ref_clk) disable iff (reset)
    stall |=> (!pick_ack && !issue_valid))
    else $error("pick or issue during a frozen cycle");

  a_ack_pick: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && pk.grant_valid) |=>
      (pick_ack && pick_ack_ctx == $past(pk.grant_ctx)))
    else $error("picked group not acknowledged next cycle");

  a_flags_int: assert property (
    @(posedge ref_clk) disable iff (reset)
    (issue_valid && (issue_u_cls == CLS_INT || issue_v_cls == CLS_INT))
      |=> wb_flags_we)
    else $error("integer issue did not evaluate the flags");

  a_wb_idle: assert property (
    @(posedge ref_clk) disable iff (reset)
    !issue_valid |=> (!wb_rf_we && !wb_flags_we))
    else $error("writeback without an issue");

  a_fill_wake: assert property (
    @(posedge ref_clk) disable iff (reset)
    (fill_done && !(load_miss && load_miss_ctx == fill_ctx)) |=>
      !ctx_suspended[$past(fill_ctx)])
    else $error("filled context still parked");

  // Latency loads; a short load would let a dependent issue too early
  a_vec_latency: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && pk.grant_valid && is_vec(g.op0)) |=>
      s.lat[$past(pk.grant_ctx)] >= LAT_VEC - LAT_STEP)
    else $error("vector result latency shorter than four clocks");

  a_store_latency: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && pk.grant_valid && g.op0 == CLS_STORE) |=>
      s.lat[$past(pk.grant_ctx)] == LAT_L1ST - LAT_STEP)
    else $error("store to load penalty not twelve clocks");

  a_swz_latency: assert property (
    @(posedge ref_clk) disable iff (reset)
    (adv && pk.grant_valid && g.op0 == CLS_VSTORE &&
      ctx_swz[pk.grant_ctx]) |=>
      s.lat[$past(pk.grant_ctx)] > LAT_VST - LAT_STEP)
    else $error("swizzle store did not lengthen the load latency");
endmodule

// >>> rtl/mtip_pick_if.sv
`timescale 1ns/100ps
interface mtip_pick_if;
  logic [mtip_pkg::NCTX-1:0] req;
  logic advance;
  logic grant_valid;
  logic [mtip_pkg::CTX_W-1:0] grant_ctx;
  modport picker (input req, input advance,
                  output grant_valid, output grant_ctx);
  modport core (output req, output advance,
                input grant_valid, input grant_ctx);
endinterface

// >>> rtl/mtip_picker.sv
`timescale 1ns/100ps
module mtip_picker (
  input wire logic ref_clk,
  input wire logic reset,
  mtip_pick_if.picker pk
);
  import mtip_pkg::*;

  typedef struct packed {
    mtip_ctx_t ptr;
    logic last_valid;
    mtip_ctx_t last_ctx;
  } mtip_pick_st_t;

  mtip_pick_st_t s;
  mtip_pick_st_t next_s;
  logic [NCTX-1:0] elig;
  logic found;
  mtip_ctx_t win;
  mtip_ctx_t idx;

  // Round robin from the pointer, skipping the last pick
  always_comb begin
    next_s = s;
    elig = pk.req;
    found = 1'b0;
    win = s.ptr;
    idx = s.ptr;
    if (s.last_valid) begin
      elig[s.last_ctx] = 1'b0;
    end
    for (int i = 0; i < NCTX; i++) begin
      idx = s.ptr + mtip_ctx_t'(i);
      if (!found && elig[idx]) begin
        found = 1'b1;
        win = idx;
      end
    end
    // Nothing else ready: an idle slot, never a repeat
    pk.grant_valid = found;
    pk.grant_ctx = win;
    // Pointer moves past the winner so no ready context starves
    if (pk.advance) begin
      next_s.last_valid = found;
      next_s.last_ctx = win;
      if (found) begin
        next_s.ptr = win + CTX_ONE;
      end
    end
  end

  // Exclusion memory only moves when the pipe advances
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  a_skip_last: assert property (
    @(posedge ref_clk) disable iff (reset)
    (pk.grant_valid && s.last_valid) |-> pk.grant_ctx != s.last_ctx)
    else $error("picker chose the context picked last");

  a_idle_slot: assert property (
    @(posedge ref_clk) disable iff (reset)
    (elig == '0) |-> !pk.grant_valid)
    else $error("picker granted with no eligible context");

  a_rr_order: assert property (
    @(posedge ref_clk) disable iff (reset)
    (pk.grant_valid && elig[s.ptr]) |-> pk.grant_ctx == s.ptr)
    else $error("picker skipped the round robin head");
endmodule

// >>> rtl/mtip_pkg.sv
package mtip_pkg;
  localparam int NCTX = 4;
  localparam int CTX_W = 2;
  localparam int LAT_W = 5;

  typedef logic [CTX_W-1:0] mtip_ctx_t;
  typedef logic [LAT_W-1:0] mtip_lat_t;
  typedef logic [7:0] mtip_byte_t;
  typedef logic [1:0] mtip_cnt_t;

  typedef enum logic [2:0] {
    CLS_NONE   = 3'h0,
    CLS_INT    = 3'h1,
    CLS_MASK   = 3'h2,
    CLS_VEC    = 3'h3,
    CLS_VSTORE = 3'h4,
    CLS_STORE  = 3'h5,
    CLS_LOAD   = 3'h6,
    CLS_BRANCH = 3'h7
  } mtip_cls_t;

  localparam mtip_ctx_t CTX_ONE = 2'h1;
  localparam mtip_cnt_t CNT_ONE = 2'h1;
  localparam mtip_lat_t LAT_ZERO = 5'h00;
  localparam mtip_lat_t LAT_STEP = 5'h01;
  // Result latencies in clocks
  localparam mtip_lat_t LAT_INT = 5'h01;
  localparam mtip_lat_t LAT_VEC = 5'h04;
  localparam mtip_lat_t LAT_VST = 5'h04;
  localparam mtip_lat_t LAT_L1ST = 5'h0c;
  localparam mtip_lat_t LAT_SWZ = 5'h02;
  // Dead clocks of a bounce, extra cycles of a slow prefix
  localparam mtip_cnt_t DEAD_CLKS = 2'h2;
  localparam mtip_cnt_t SLOW_CLKS = 2'h2;

  // Prefix bytes
  localparam mtip_byte_t PFX_X62 = 8'h62;
  localparam mtip_byte_t PFX_XC4 = 8'hc4;
  localparam mtip_byte_t PFX_XC5 = 8'hc5;
  localparam mtip_byte_t PFX_X0F = 8'h0f;
  localparam mtip_byte_t PFX_XD6 = 8'hd6;
  localparam logic [3:0] PFX_REX_HI = 4'h4;
  localparam mtip_byte_t PFX_OPSZ = 8'h66;
  localparam mtip_byte_t PFX_ADSZ = 8'h67;
  localparam mtip_byte_t PFX_LOCK = 8'hf0;
  localparam mtip_byte_t PFX_REPNE = 8'hf2;
  localparam mtip_byte_t PFX_REP = 8'hf3;
  localparam mtip_byte_t PFX_SEG_ES = 8'h26;
  localparam mtip_byte_t PFX_SEG_CS = 8'h2e;
  localparam mtip_byte_t PFX_SEG_SS = 8'h36;
  localparam mtip_byte_t PFX_SEG_DS = 8'h3e;
  localparam mtip_byte_t PFX_SEG_FS = 8'h64;
  localparam mtip_byte_t PFX_SEG_GS = 8'h65;

  typedef struct packed {
    logic valid;
    mtip_ctx_t ctx;
    mtip_byte_t prefix;
    mtip_cls_t op0;
    mtip_cls_t op1;
    logic early;
  } mtip_grp_t;

  function automatic logic pfx_rex(mtip_byte_t b);
    return b[7:4] == PFX_REX_HI;
  endfunction

  function automatic logic pfx_fast(mtip_byte_t b);
    return b == PFX_X62 || b == PFX_XC4 || b == PFX_XC5 ||
           b == PFX_X0F || pfx_rex(b);
  endfunction

  function automatic logic pfx_early(mtip_byte_t b);
    return b == PFX_X0F || b == PFX_X62 || b == PFX_XD6 || pfx_rex(b);
  endfunction

  function automatic logic pfx_slow(mtip_byte_t b);
    return b == PFX_OPSZ || b == PFX_ADSZ || b == PFX_LOCK ||
           b == PFX_REPNE || b == PFX_REP || b == PFX_SEG_ES ||
           b == PFX_SEG_CS || b == PFX_SEG_SS || b == PFX_SEG_DS ||
           b == PFX_SEG_FS || b == PFX_SEG_GS;
  endfunction

  function automatic logic is_vec(mtip_cls_t c);
    return c == CLS_VEC || c == CLS_VSTORE;
  endfunction

  function automatic logic v_ok(mtip_cls_t c);
    return c == CLS_INT || c == CLS_MASK || c == CLS_LOAD ||
           c == CLS_STORE || c == CLS_BRANCH;
  endfunction

  function automatic logic writes_gpr(mtip_cls_t c);
    return c == CLS_INT || c == CLS_LOAD;
  endfunction

  function automatic mtip_lat_t cls_lat(mtip_cls_t c, logic swz);
    mtip_lat_t extra;
    extra = swz ? LAT_SWZ : LAT_ZERO;
    unique case (c)
      CLS_VEC: return LAT_VEC + extra;
      CLS_VSTORE: return LAT_VST + extra;
      CLS_STORE: return LAT_L1ST;
      default: return LAT_INT;
    endcase
  endfunction
endpackage

// >>> tb/mtip_l2_model.sv
`timescale 1ns/100ps
// Core-ring side: load misses, fills and cache bounces
module mtip_l2_model (
  input wire logic ref_clk,
  output logic load_miss,
  output mtip_pkg::mtip_ctx_t load_miss_ctx,
  output logic fill_done,
  output mtip_pkg::mtip_ctx_t fill_ctx,
  output logic dcache_bounce
);
  import mtip_pkg::*;
  // Quiet until asked
  initial begin
    load_miss = 1'b0;
    load_miss_ctx = 2'h0;
    fill_done = 1'b0;
    fill_ctx = 2'h0;
    dcache_bounce = 1'b0;
  end
  // Miss, then fill after dly cycles; ctx lines flip once released
  task automatic miss(input mtip_ctx_t c, input int dly);
    @(negedge ref_clk);
    load_miss = 1'b1;
    load_miss_ctx = c;
    @(negedge ref_clk);
    load_miss = 1'b0;
    load_miss_ctx = ~c;
    repeat (dly) @(negedge ref_clk);
    fill_done = 1'b1;
    fill_ctx = c;
    @(negedge ref_clk);
    fill_done = 1'b0;
    fill_ctx = ~c;
  endtask
  // One-cycle bank conflict report
  task automatic bounce();
    @(negedge ref_clk);
    dcache_bounce = 1'b1;
    @(negedge ref_clk);
    dcache_bounce = 1'b0;
  endtask
endmodule

// >>> tb/tb_multithread_issue_pipeline.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_multithread_issue_pipeline;
  import mtip_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [NCTX-1:0] vld, dep, swz, susp;
  mtip_byte_t [NCTX-1:0] pfx;
  mtip_cls_t [NCTX-1:0] op0, op1;
  logic load_miss, fill_done, dcache_bounce;
  mtip_ctx_t load_miss_ctx, fill_ctx, pick_ack_ctx, issue_ctx, wb_ctx;
  logic pick_ack, pick_ack_two, issue_valid, issue_early_pfx;
  logic wb_rf_we, wb_flags_we, prev_v, erl;
  mtip_cls_t issue_u_cls, issue_v_cls;
  mtip_ctx_t prev_c;
  int num_errors = 0;
  int compares = 0;
  int iss, iss0, gap0, rep, cyc, last0;

  // 50 MHz core clock
  always #10 ref_clk = ~ref_clk;

  mtip_core i_dut (.ref_clk(ref_clk), .reset(reset), .ctx_valid(vld),
    .ctx_prefix(pfx), .ctx_op0(op0), .ctx_op1(op1), .ctx_dep(dep),
    .ctx_swz(swz), .load_miss(load_miss), .load_miss_ctx(load_miss_ctx),
    .fill_done(fill_done), .fill_ctx(fill_ctx),
    .dcache_bounce(dcache_bounce), .pick_ack(pick_ack),
    .pick_ack_ctx(pick_ack_ctx), .pick_ack_two(pick_ack_two),
    .issue_valid(issue_valid), .issue_ctx(issue_ctx),
    .issue_u_cls(issue_u_cls), .issue_v_cls(issue_v_cls),
    .issue_early_pfx(issue_early_pfx), .wb_rf_we(wb_rf_we),
    .wb_flags_we(wb_flags_we), .wb_ctx(wb_ctx), .ctx_suspended(susp));

  mtip_l2_model i_l2 (.ref_clk(ref_clk), .load_miss(load_miss),
    .load_miss_ctx(load_miss_ctx), .fill_done(fill_done),
    .fill_ctx(fill_ctx), .dcache_bounce(dcache_bounce));

  // Step n cycles, tallying issues at the settled falling edge
  task automatic run(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      cyc++;
      if (issue_valid === 1'b1) begin
        iss++;
        erl = issue_early_pfx;
        if (prev_v === 1'b1 && prev_c === issue_ctx) rep++;
        if (issue_ctx === 2'h0) begin
          gap0 = cyc - last0;
          last0 = cyc;
          iss0++;
        end
      end
      prev_v = issue_valid;
      prev_c = issue_ctx;
    end
  endtask

  // Clear tallies
  task automatic clr();
    iss = 0;
    iss0 = 0;
    rep = 0;
  endtask

  // Same group on every context; only called at a falling edge
  task automatic setc(input logic [3:0] m, input mtip_byte_t p,
                      input mtip_cls_t a, input mtip_cls_t b,
                      input logic d, input logic s);
    vld = m;
    for (int i = 0; i < NCTX; i++) begin
      pfx[i] = p;
      op0[i] = a;
      op1[i] = b;
      dep[i] = d;
      swz[i] = s;
    end
  endtask

  // Drain so long store counters cannot leak into the next case
  task automatic idle();
    setc(4'h0, 8'h00, CLS_NONE, CLS_NONE, 1'b0, 1'b0);
    run(16);
  endtask

  // Pick to issue spacing on context 3
  task automatic s_lat();
    int k;
    idle();
    setc(4'h8, 8'h00, CLS_INT, CLS_NONE, 1'b0, 1'b0);
    k = 0;
    while (pick_ack !== 1'b1 && k < 10) begin
      run(1);
      k++;
    end
    `CHK(pick_ack, 1'b1)
    `CHK(pick_ack_ctx, 2'h3)
    run(2);
    `CHK(issue_valid, 1'b1)
    `CHK(issue_ctx, 2'h3)
  endtask

  // One thread alone: every other slot idle
  task automatic s_single();
    idle();
    setc(4'h1, 8'h00, CLS_INT, CLS_NONE, 1'b0, 1'b0);
    run(6);
    clr();
    run(20);
    `CHK(iss, 10)
    `CHK(rep, 0)
  endtask

  // Four threads: back-to-back dual issue in rotation
  task automatic s_rr();
    mtip_ctx_t c;
    setc(4'hf, 8'h00, CLS_INT, CLS_INT, 1'b0, 1'b0);
    run(6);
    for (int k = 0; k < 8; k++) begin
      c = issue_ctx;
      run(1);
      `CHK(issue_valid, 1'b1)
      `CHK(pick_ack, 1'b1)
      `CHK(issue_ctx, c + CTX_ONE)
      `CHK(issue_v_cls, CLS_INT)
      `CHK(wb_ctx, c)
    end
  endtask

  // Every class offered to the secondary pipe
  task automatic s_pair();
    mtip_cls_t c;
    logic ok;
    for (int k = 0; k < 8; k++) begin
      c = mtip_cls_t'(k);
      ok = c inside {CLS_INT, CLS_MASK, CLS_STORE, CLS_LOAD, CLS_BRANCH};
      setc(4'hf, 8'h00, CLS_MASK, c, 1'b0, 1'b0);
      run(8);
      `CHK(issue_u_cls, CLS_MASK)
      `CHK(issue_v_cls, ok ? c : CLS_NONE)
      `CHK(pick_ack_two, ok)
      `CHK(wb_rf_we, ok && c inside {CLS_INT, CLS_LOAD})
      `CHK(wb_flags_we, ok && c == CLS_INT)
    end
  endtask

  // Dependent chains; short latencies are masked by alternation
  task automatic s_dep();
    mtip_cls_t dc[7] = '{CLS_INT, CLS_MASK, CLS_VEC, CLS_VEC, CLS_VSTORE,
                         CLS_VSTORE, CLS_STORE};
    logic ds[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int dg[7] = '{2, 2, 4, 6, 4, 6, 12};
    for (int k = 0; k < 7; k++) begin
      idle();
      setc(4'h1, 8'h00, dc[k], CLS_NONE, 1'b1, ds[k]);
      run(30);
      `CHK(gap0, dg[k])
    end
    setc(4'hf, 8'h00, CLS_VEC, CLS_NONE, 1'b0, 1'b0);
    run(6);
    clr();
    run(8);
    `CHK(iss, 8)
  endtask

  // Fast and slow prefixes; first four are spotted early
  task automatic s_pfx();
    mtip_byte_t pt[17] = '{8'h0f, 8'h62, 8'hd6, 8'h4a, 8'hc4, 8'hc5,
      8'h66, 8'h67, 8'hf0, 8'hf2, 8'hf3, 8'h26, 8'h2e, 8'h36, 8'h3e,
      8'h64, 8'h65};
    for (int k = 0; k < 17; k++) begin
      setc(4'hf, pt[k], CLS_INT, CLS_NONE, 1'b0, 1'b0);
      run(10);
      clr();
      run(12);
      `CHK(iss, k > 5 ? 4 : 12)
      `CHK(erl, k < 4)
    end
  endtask

  // Bounce in full flow loses exactly two slots
  task automatic s_bounce();
    setc(4'hf, 8'h00, CLS_INT, CLS_NONE, 1'b0, 1'b0);
    run(6);
    clr();
    fork
      i_l2.bounce();
    join_none
    run(8);
    `CHK(iss, 6)
    `CHK(rep, 0)
  endtask

  // Slow fill parks context 0 while context 1 keeps going
  task automatic s_miss();
    idle();
    setc(4'h3, 8'h00, CLS_INT, CLS_NONE, 1'b0, 1'b0);
    run(6);
    fork
      i_l2.miss(2'h0, 20);
    join_none
    run(8);
    clr();
    run(12);
    `CHK(iss0, 0)
    `CHK(iss, 6)
    `CHK(susp, 4'h1)
    run(12);
    clr();
    run(8);
    `CHK(susp, 4'h0)
    `CHK(iss0, 4)
  endtask

  // Verdict
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    cyc = 0;
    last0 = 0;
    gap0 = 0;
    prev_v = 1'b0;
    prev_c = 2'h0;
    erl = 1'b0;
    clr();
    setc(4'h0, 8'h00, CLS_NONE, CLS_NONE, 1'b0, 1'b0);
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    s_lat();
    s_single();
    s_rr();
    s_pair();
    s_dep();
    s_pfx();
    s_bounce();
    s_miss();
    end_sim();
  end

  // Watchdog, well beyond the roughly 900 cycles the cases need
  initial begin
    repeat (6000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
endmodule
